// *** logic/efu_defs.svh ***
// Address map, field positions and reset values of the event unit
`ifndef EFU_DEFS_SVH
`define EFU_DEFS_SVH

// ---------------------------------------------------------------------------
// Widths
// ---------------------------------------------------------------------------
`define EFU_EVT_W           28
`define EFU_OUT_W           12
`define EFU_GPI_W           2
`define EFU_ADDR_W          16
`define EFU_DATA_W          32

// ---------------------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------------------
`define EFU_A_FREQ_SEL      16'h0020
`define EFU_A_CTRL          16'h0220
`define EFU_A_INT_EN        16'h0224
`define EFU_A_FAULT_EN      16'h0228
`define EFU_A_EVENT         16'h022C
`define EFU_A_EVT_GEN       16'h0234
`define EFU_A_OUT_CTRL      16'h0238
`define EFU_A_DEV_STS       16'h0284
`define EFU_A_GPIO_STS      16'h0290
`define EFU_A_SIG_EXP       16'h02E0
`define EFU_A_LOCK          16'h02E4

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define EFU_CTRL_INT_GATE   0
`define EFU_CTRL_FAULT_GATE 1
`define EFU_CTRL_INT_PIN    2
`define EFU_CTRL_RELOAD     3
`define EFU_CTRL_W          4
`define EFU_FSEL_W          8
`define EFU_EVT_APLL_LOL    0
`define EFU_EVT_FREQ_LO     7
`define EFU_EVT_FREQ_HI     18
`define EFU_EVT_CRC         19
`define EFU_EVT_SIG_FAIL    22
`define EFU_EVT_SIG_RELOAD  23
`define EFU_STS_INT         0
`define EFU_STS_XTAL        1
`define EFU_LOCK_BIT        0

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define EFU_RST_CTRL        4'h0
`define EFU_RST_LOCK        1'b1

`endif

// *** logic/efu_dev.sv ***
// Event capture, interrupt and fault unit: device end
`timescale 1ns/1ps
`include "efu_defs.svh"
module efu_dev
    import efu_pkg::*;
#(
    parameter logic [`EFU_DATA_W-1:0] SIG_EXP_RST = 32'h0000_0000
) (
    input  wire logic                   CLK,
    input  wire logic                   ARST_N,
    input  wire logic                   CE,
    efu_if.dev                          LINK,
    input  wire logic [`EFU_EVT_W-1:0]  MON_EVT,
    input  wire logic [`EFU_DATA_W-1:0] SIG_CALC,
    input  wire logic [`EFU_GPI_W-1:0]  GPI_IN,
    input  wire logic                   XTAL_SEL,
    output logic [`EFU_OUT_W-1:0]       OUT_EN,
    output logic                        SAFE_STATE
);

    // -----------------------------------------------------------------------
    // Address decode
    // -----------------------------------------------------------------------
    function automatic logic hit(
        input logic [`EFU_ADDR_W-1:0] a,
        input logic [`EFU_ADDR_W-1:0] target
    );
        hit = (a == target);
    endfunction : hit

    efu_dev_st_t st_ff;
    efu_dev_st_t nxt_st;

    logic                   take;
    logic                   wr;
    logic                   crc_bad;
    logic [`EFU_EVT_W-1:0]  clr_mask;
    logic [`EFU_EVT_W-1:0]  mon_set;
    logic [`EFU_EVT_W-1:0]  gen_set;
    logic                   sig_bad;
    logic                   int_cond;
    logic                   fault_cond;
    logic                   fault_real;
    logic [`EFU_DATA_W-1:0] rd_word;

    // -----------------------------------------------------------------------
    // Gated outputs
    // -----------------------------------------------------------------------
    efu_gate #(
        .W(`EFU_EVT_W)
    ) u_int_gate (
        .FLAGS (st_ff.flags),
        .MASK  (st_ff.int_en),
        .GATE  (st_ff.ctrl[`EFU_CTRL_INT_GATE]),
        .HIT   (int_cond)
    );

    efu_gate #(
        .W(`EFU_EVT_W)
    ) u_fault_gate (
        .FLAGS (st_ff.flags),
        .MASK  (st_ff.fault_en),
        .GATE  (st_ff.ctrl[`EFU_CTRL_FAULT_GATE]),
        .HIT   (fault_cond)
    );

    efu_gate #(
        .W(`EFU_EVT_W)
    ) u_safe_gate (
        .FLAGS (st_ff.real_flags),
        .MASK  (st_ff.fault_en),
        .GATE  (st_ff.ctrl[`EFU_CTRL_FAULT_GATE]),
        .HIT   (fault_real)
    );

    assign LINK.int_pin   = int_cond & st_ff.ctrl[`EFU_CTRL_INT_PIN];
    assign LINK.fault_pin = fault_cond;
    assign LINK.ack       = st_ff.ack;
    assign LINK.rdata     = st_ff.rdata;
    assign SAFE_STATE     = st_ff.safe;

    // Alarmed outputs stay off until software clears their event flag
    always_comb begin
        OUT_EN = ~(st_ff.out_dis
                   | st_ff.real_flags[`EFU_EVT_FREQ_HI:`EFU_EVT_FREQ_LO]);
        if (st_ff.safe) begin
            OUT_EN = '0;
        end
    end

    // -----------------------------------------------------------------------
    // Link access
    // -----------------------------------------------------------------------
    assign take    = LINK.req & ~st_ff.ack;
    assign wr      = take & LINK.we & LINK.crc_ok;
    assign crc_bad = take & ~LINK.crc_ok;
    assign sig_bad = (SIG_CALC != st_ff.sig_exp);

    // -----------------------------------------------------------------------
    // Event sources
    // -----------------------------------------------------------------------
    always_comb begin
        clr_mask = '0;
        gen_set  = '0;
        mon_set  = MON_EVT;
        if (wr && hit(LINK.addr, `EFU_A_EVENT)) begin
            clr_mask = LINK.wdata[`EFU_EVT_W-1:0];
        end
        if (wr && hit(LINK.addr, `EFU_A_EVT_GEN)) begin
            gen_set = LINK.wdata[`EFU_EVT_W-1:0];
        end
        if (crc_bad) begin
            mon_set[`EFU_EVT_CRC] = 1'b1;
        end
        if (sig_bad) begin
            if (st_ff.ctrl[`EFU_CTRL_RELOAD]) begin
                mon_set[`EFU_EVT_SIG_RELOAD] = 1'b1;
            end else begin
                mon_set[`EFU_EVT_SIG_FAIL] = 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------------
    // Read mux
    // -----------------------------------------------------------------------
    always_comb begin
        rd_word = '0;
        case (LINK.addr)
            `EFU_A_CTRL: begin
                rd_word[`EFU_CTRL_W-1:0] = st_ff.ctrl;
            end
            `EFU_A_INT_EN: begin
                rd_word[`EFU_EVT_W-1:0] = st_ff.int_en;
            end
            `EFU_A_FAULT_EN: begin
                rd_word[`EFU_EVT_W-1:0] = st_ff.fault_en;
            end
            `EFU_A_EVENT: begin
                rd_word[`EFU_EVT_W-1:0] = st_ff.flags;
            end
            `EFU_A_EVT_GEN: begin
                rd_word[`EFU_EVT_W-1:0] = st_ff.gen;
            end
            `EFU_A_OUT_CTRL: begin
                rd_word[`EFU_OUT_W-1:0] = st_ff.out_dis;
            end
            `EFU_A_FREQ_SEL: begin
                rd_word[`EFU_FSEL_W-1:0] = st_ff.freq_sel;
            end
            `EFU_A_DEV_STS: begin
                rd_word[`EFU_STS_INT]  = int_cond;
                rd_word[`EFU_STS_XTAL] = XTAL_SEL;
            end
            `EFU_A_GPIO_STS: begin
                rd_word[`EFU_GPI_W-1:0] = GPI_IN;
            end
            `EFU_A_SIG_EXP: begin
                rd_word = st_ff.sig_exp;
            end
            `EFU_A_LOCK: begin
                rd_word[`EFU_LOCK_BIT] = st_ff.lock;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // -----------------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------------
    always_comb begin
        nxt_st     = st_ff;
        nxt_st.ack = take;
        if (take) begin
            nxt_st.rdata = (LINK.we || crc_bad) ? '0 : rd_word;
        end
        // Set wins over a clear in the same cycle
        nxt_st.flags      = (st_ff.flags & ~clr_mask)
                            | mon_set | gen_set;
        // Source-only copy keeps injected events off OUT_EN and SAFE_STATE
        nxt_st.real_flags = (st_ff.real_flags & ~clr_mask)
                            | mon_set;
        nxt_st.safe       = st_ff.safe | fault_real;
        if (wr) begin
            case (LINK.addr)
                `EFU_A_CTRL: begin
                    nxt_st.ctrl = LINK.wdata[`EFU_CTRL_W-1:0];
                end
                `EFU_A_INT_EN: begin
                    nxt_st.int_en = LINK.wdata[`EFU_EVT_W-1:0];
                end
                `EFU_A_FAULT_EN: begin
                    nxt_st.fault_en = LINK.wdata[`EFU_EVT_W-1:0];
                end
                `EFU_A_EVT_GEN: begin
                    nxt_st.gen = LINK.wdata[`EFU_EVT_W-1:0];
                end
                `EFU_A_OUT_CTRL: begin
                    nxt_st.out_dis = LINK.wdata[`EFU_OUT_W-1:0];
                end
                `EFU_A_FREQ_SEL: begin
                    nxt_st.freq_sel = LINK.wdata[`EFU_FSEL_W-1:0];
                end
                `EFU_A_SIG_EXP: begin
                    if (!st_ff.lock) begin
                        nxt_st.sig_exp = LINK.wdata;
                    end
                end
                `EFU_A_LOCK: begin
                    nxt_st.lock = LINK.wdata[`EFU_LOCK_BIT];
                end
                default: begin
                    nxt_st.lock = st_ff.lock;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_ff            <= '0;
            st_ff.ctrl       <= `EFU_RST_CTRL;
            st_ff.lock       <= `EFU_RST_LOCK;
            st_ff.sig_exp    <= SIG_EXP_RST;
        end else if (CE) begin
            st_ff <= nxt_st;
        end
    end

endmodule : efu_dev

// *** logic/efu_gate.sv ***
// Masked OR of event flags behind a global gate
`timescale 1ns/1ps
module efu_gate #(
    parameter int W = 28
) (
    input  wire logic [W-1:0] FLAGS,
    input  wire logic [W-1:0] MASK,
    input  wire logic         GATE,
    output logic              HIT
);
    assign HIT = GATE & (|(FLAGS & MASK));
endmodule : efu_gate

// *** logic/efu_host.sv ***
// Host end: single register accesses and output event service
`timescale 1ns/1ps
`include "efu_defs.svh"
module efu_host
    import efu_pkg::*;
(
    input  wire logic                   CLK,
    input  wire logic                   ARST_N,
    input  wire logic                   CE,
    efu_if.host                         LINK,
    input  wire logic                   CMD_VALID,
    input  wire logic                   CMD_WE,
    input  wire logic [`EFU_ADDR_W-1:0] CMD_ADDR,
    input  wire logic [`EFU_DATA_W-1:0] CMD_WDATA,
    input  wire logic                   CMD_BAD_CRC,
    output logic                        CMD_READY,
    output logic                        RSP_VALID,
    output logic [`EFU_DATA_W-1:0]      RSP_DATA,
    input  wire logic                   SVC_START,
    input  wire logic [3:0]             SVC_OUT,
    input  wire logic [`EFU_OUT_W-1:0]  SVC_KEEP,
    output logic                        SVC_BUSY,
    output logic [`EFU_EVT_W-1:0]       EVT_SNAP,
    output logic [`EFU_EVT_W-1:0]       MSK_SNAP,
    output logic                        INT_SEEN,
    output logic                        FAULT_SEEN
);

    efu_host_st_t st_ff;
    efu_host_st_t nxt_st;
    logic [4:0]   evt_bit;

    assign LINK.req    = st_ff.req;
    assign LINK.we     = st_ff.we;
    assign LINK.addr   = st_ff.addr;
    assign LINK.wdata  = st_ff.wdata;
    assign LINK.crc_ok = st_ff.crc_ok;
    assign CMD_READY   = (st_ff.state == EFU_H_IDLE) & ~SVC_START;
    assign SVC_BUSY    = (st_ff.state != EFU_H_IDLE)
                         & (st_ff.state != EFU_H_SINGLE);
    assign RSP_VALID   = st_ff.rsp_valid;
    assign RSP_DATA    = st_ff.rsp_data;
    assign EVT_SNAP    = st_ff.evt_snap;
    assign MSK_SNAP    = st_ff.msk_snap;
    assign INT_SEEN    = st_ff.int_seen;
    assign FAULT_SEEN  = st_ff.fault_seen;
    assign evt_bit     = 5'(`EFU_EVT_FREQ_LO) + {1'b0, st_ff.idx};

    // -----------------------------------------------------------------------
    // Sequencer
    // -----------------------------------------------------------------------
    always_comb begin
        nxt_st            = st_ff;
        nxt_st.rsp_valid  = 1'b0;
        nxt_st.int_seen   = LINK.int_pin;
        nxt_st.fault_seen = LINK.fault_pin;
        case (st_ff.state)
            EFU_H_IDLE: begin
                nxt_st.crc_ok = 1'b1;
                if (SVC_START) begin
                    nxt_st.idx   = SVC_OUT;
                    nxt_st.keep  = SVC_KEEP;
                    nxt_st.req   = 1'b1;
                    nxt_st.we    = 1'b0;
                    nxt_st.addr  = `EFU_A_EVENT;
                    nxt_st.state = EFU_H_RD_EVT;
                end else if (CMD_VALID) begin
                    nxt_st.req    = 1'b1;
                    nxt_st.we     = CMD_WE;
                    nxt_st.addr   = CMD_ADDR;
                    nxt_st.wdata  = CMD_WDATA;
                    nxt_st.crc_ok = ~CMD_BAD_CRC;
                    nxt_st.state  = EFU_H_SINGLE;
                end
            end
            EFU_H_RD_EVT: begin
                if (LINK.ack) begin
                    nxt_st.evt_snap = LINK.rdata[`EFU_EVT_W-1:0];
                    nxt_st.addr     = `EFU_A_INT_EN;
                    nxt_st.state    = EFU_H_RD_MSK;
                end
            end
            EFU_H_RD_MSK: begin
                if (LINK.ack) begin
                    nxt_st.msk_snap = LINK.rdata[`EFU_EVT_W-1:0];
                    nxt_st.we       = 1'b1;
                    nxt_st.addr     = `EFU_A_OUT_CTRL;
                    nxt_st.wdata    = {{(`EFU_DATA_W-`EFU_OUT_W){1'b0}},
                                       st_ff.keep}
                                      | (32'h0000_0001 << st_ff.idx);
                    nxt_st.state    = EFU_H_WR_DIS;
                end
            end
            EFU_H_WR_DIS: begin
                if (LINK.ack) begin
                    nxt_st.addr  = `EFU_A_FREQ_SEL;
                    nxt_st.wdata = '0;
                    nxt_st.state = EFU_H_WR_SEL;
                end
            end
            EFU_H_WR_SEL: begin
                if (LINK.ack) begin
                    nxt_st.addr  = `EFU_A_EVENT;
                    nxt_st.wdata = 32'h0000_0001 << evt_bit;
                    nxt_st.state = EFU_H_WR_CLR;
                end
            end
            EFU_H_WR_CLR: begin
                if (LINK.ack) begin
                    nxt_st.req   = 1'b0;
                    nxt_st.we    = 1'b0;
                    nxt_st.state = EFU_H_IDLE;
                end
            end
            EFU_H_SINGLE: begin
                if (LINK.ack) begin
                    nxt_st.req       = 1'b0;
                    nxt_st.rsp_valid = 1'b1;
                    nxt_st.rsp_data  = LINK.rdata;
                    nxt_st.state     = EFU_H_IDLE;
                end
            end
            default: begin
                nxt_st.req   = 1'b0;
                nxt_st.state = EFU_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_ff        <= '0;
            st_ff.crc_ok <= 1'b1;
        end else if (CE) begin
            st_ff <= nxt_st;
        end
    end

endmodule : efu_host

// *** logic/efu_if.sv ***
// Management link and event pins between host and event unit
`timescale 1ns/1ps
`include "efu_defs.svh"
interface efu_if;
    logic                   req;
    logic                   we;
    logic [`EFU_ADDR_W-1:0] addr;
    logic [`EFU_DATA_W-1:0] wdata;
    logic                   crc_ok;
    logic                   ack;
    logic [`EFU_DATA_W-1:0] rdata;
    logic                   int_pin;
    logic                   fault_pin;

    modport dev (
        input  req,
        input  we,
        input  addr,
        input  wdata,
        input  crc_ok,
        output ack,
        output rdata,
        output int_pin,
        output fault_pin
    );

    modport host (
        output req,
        output we,
        output addr,
        output wdata,
        output crc_ok,
        input  ack,
        input  rdata,
        input  int_pin,
        input  fault_pin
    );
endinterface : efu_if

// *** logic/efu_pkg.sv ***
// Types shared by both ends of the event unit
package efu_pkg;
    `include "efu_defs.svh"

    typedef enum logic [2:0] {
        EFU_H_IDLE   = 3'h0,
        EFU_H_RD_EVT = 3'h1,
        EFU_H_RD_MSK = 3'h3,
        EFU_H_WR_DIS = 3'h2,
        EFU_H_WR_SEL = 3'h6,
        EFU_H_WR_CLR = 3'h7,
        EFU_H_SINGLE = 3'h4
    } efu_hstate_t;

    typedef struct packed {
        logic [`EFU_EVT_W-1:0]  flags;
        logic [`EFU_EVT_W-1:0]  real_flags;
        logic [`EFU_EVT_W-1:0]  int_en;
        logic [`EFU_EVT_W-1:0]  fault_en;
        logic [`EFU_EVT_W-1:0]  gen;
        logic [`EFU_CTRL_W-1:0] ctrl;
        logic [`EFU_OUT_W-1:0]  out_dis;
        logic [`EFU_FSEL_W-1:0] freq_sel;
        logic [`EFU_DATA_W-1:0] sig_exp;
        logic                   lock;
        logic                   safe;
        logic                   ack;
        logic [`EFU_DATA_W-1:0] rdata;
    } efu_dev_st_t;

    typedef struct packed {
        efu_hstate_t            state;
        logic                   req;
        logic                   we;
        logic [`EFU_ADDR_W-1:0] addr;
        logic [`EFU_DATA_W-1:0] wdata;
        logic                   crc_ok;
        logic                   rsp_valid;
        logic [`EFU_DATA_W-1:0] rsp_data;
        logic [3:0]             idx;
        logic [`EFU_OUT_W-1:0]  keep;
        logic [`EFU_EVT_W-1:0]  evt_snap;
        logic [`EFU_EVT_W-1:0]  msk_snap;
        logic                   int_seen;
        logic                   fault_seen;
    } efu_host_st_t;

endpackage : efu_pkg

// *** test/efu_link_props.sv ***
// Link and pin checks between host and event unit
`timescale 1ns/1ps
`include "efu_defs.svh"
module efu_link_chk (
    input wire logic                   CLK,
    input wire logic                   ARST_N,
    input wire logic                   req,
    input wire logic                   we,
    input wire logic [`EFU_ADDR_W-1:0] addr,
    input wire logic [`EFU_DATA_W-1:0] wdata,
    input wire logic                   crc_ok,
    input wire logic                   ack,
    input wire logic [`EFU_DATA_W-1:0] rdata,
    input wire logic                   int_pin,
    input wire logic                   fault_pin
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    chk_ack_single: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    chk_ack_follows: assert property (req && !ack |=> ack)
        else $error("request not answered next cycle");
    chk_idle_quiet: assert property (!req |=> !ack)
        else $error("ack without request");
    chk_req_held: assert property (req && !ack |=> req)
        else $error("request dropped before ack");
    chk_write_zero: assert property (req && we && !ack |=> rdata == '0)
        else $error("write answered with data");
    chk_bad_check: assert property (
        req && !crc_ok && !ack |=> ack && rdata == '0)
        else $error("bad check access not refused");
    chk_mask_off: assert property (
        req && we && crc_ok && !ack && addr == `EFU_A_INT_EN
        && wdata == '0 |-> ##2 (!int_pin)[*2])
        else $error("interrupt pin high with mask clear");
    chk_unmapped_zero: assert property (
        req && !we && !ack && addr == 16'h0100 |=> rdata == '0)
        else $error("unmapped read not zero");
    chk_reset_pins: assert property (
        $rose(ARST_N) |-> !int_pin && !fault_pin)
        else $error("pins high after reset");
endmodule : efu_link_chk

// *** test/event_interrupt_fault_unit_tb.sv ***
// Bench joining host and device ends of the event unit
`timescale 1ns/1ps
`include "efu_defs.svh"
module event_interrupt_fault_unit_tb
    import efu_pkg::*;
;
    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } efu_row_t;
    efu_row_t rows [10] = '{
        '{1'b0, `EFU_A_LOCK, 32'h0, 32'h1},
        '{1'b1, `EFU_A_SIG_EXP, 32'h1234, 32'h0},
        '{1'b0, `EFU_A_GPIO_STS, 32'h0, 32'h2},
        '{1'b1, `EFU_A_DEV_STS, 32'h0, 32'h2},
        '{1'b1, 16'h0100, 32'h5, 32'h0},
        '{1'b1, `EFU_A_INT_EN, 32'hFFFFFFFF, 32'h0FFFFFFF},
        '{1'b1, `EFU_A_FAULT_EN, 32'h00300000, 32'h00300000},
        '{1'b1, `EFU_A_CTRL, 32'h5, 32'h5},
        '{1'b1, `EFU_A_FREQ_SEL, 32'h5A, 32'h5A},
        '{1'b1, `EFU_A_EVENT, 32'h0FFFFFFF, 32'h0}
    };
    logic        clk = 1'b0;
    logic        arst_n, cmd_valid, cmd_we, cmd_bad_crc, svc_start;
    logic        cmd_ready, rsp_valid, svc_busy, int_seen, fault_seen;
    logic        xtal_sel, safe_state;
    logic [15:0] cmd_addr;
    logic [31:0] cmd_wdata, rsp_data, rd, sig_calc;
    logic [3:0]  svc_out;
    logic [11:0] svc_keep, out_en;
    logic [27:0] mon_evt, evt_snap, msk_snap;
    logic [1:0]  gpi_in;
    int          n_fail, tests_run;
    efu_if lnk ();
    efu_dev i_efu_dev (.CLK(clk), .ARST_N(arst_n), .CE(1'b1), .LINK(lnk),
        .MON_EVT(mon_evt), .SIG_CALC(sig_calc), .GPI_IN(gpi_in),
        .XTAL_SEL(xtal_sel), .OUT_EN(out_en), .SAFE_STATE(safe_state));
    efu_host i_efu_host (.CLK(clk), .ARST_N(arst_n), .CE(1'b1),
        .LINK(lnk), .CMD_VALID(cmd_valid), .CMD_WE(cmd_we),
        .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
        .CMD_BAD_CRC(cmd_bad_crc), .CMD_READY(cmd_ready),
        .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
        .SVC_START(svc_start), .SVC_OUT(svc_out), .SVC_KEEP(svc_keep),
        .SVC_BUSY(svc_busy), .EVT_SNAP(evt_snap), .MSK_SNAP(msk_snap),
        .INT_SEEN(int_seen), .FAULT_SEEN(fault_seen));
    efu_link_chk i_efu_link_chk (.CLK(clk), .ARST_N(arst_n),
        .req(lnk.req), .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata),
        .crc_ok(lnk.crc_ok), .ack(lnk.ack), .rdata(lnk.rdata),
        .int_pin(lnk.int_pin), .fault_pin(lnk.fault_pin));
    always #20 clk = ~clk;
    // ----
    // Tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [31:0] d, input logic b);
        int i;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_we <= w;
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_bad_crc <= b;
        @(negedge clk);
        for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge clk);
        @(posedge clk);
        cmd_valid <= 1'b0;
        for (i = 0; i < 50 && rsp_valid !== 1'b1; i++) @(negedge clk);
        if (rsp_valid !== 1'b1) n_fail++;
        rd = rsp_data;
    endtask : acc
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 1'b0);
    endtask : wr
    task automatic rdc(input logic [15:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0, 1'b0);
        check(rd, e);
    endtask : rdc
    task automatic pulse(input logic [27:0] bits);
        @(posedge clk);
        mon_evt <= bits;
        @(posedge clk);
        mon_evt <= '0;
        repeat (4) @(negedge clk);
    endtask : pulse
    task automatic print_verdict();
        if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
    // ----
    // Main sequence
    // ----
    initial begin
        int i;
        {arst_n, cmd_valid, cmd_we, cmd_bad_crc, svc_start} = '0;
        {cmd_addr, cmd_wdata, svc_out, svc_keep, mon_evt, sig_calc} = '0;
        gpi_in = 2'h2;
        xtal_sel = 1'b1;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        foreach (rows[k]) begin
            if (rows[k].we) wr(rows[k].addr, rows[k].wdata);
            rdc(rows[k].addr, rows[k].exp);
        end
        pulse(28'h1);
        rdc(`EFU_A_EVENT, 32'h1);
        check({31'h0, int_seen}, 32'h1);
        rdc(`EFU_A_DEV_STS, 32'h3);
        wr(`EFU_A_EVENT, 32'h1);
        rdc(`EFU_A_EVENT, 32'h0);
        check({31'h0, int_seen}, 32'h0);
        @(posedge clk);
        mon_evt <= 28'h2;
        wr(`EFU_A_EVENT, 32'h2);
        rdc(`EFU_A_EVENT, 32'h2);
        wr(`EFU_A_INT_EN, 32'h0);
        rdc(`EFU_A_EVENT, 32'h2);
        check({31'h0, int_seen}, 32'h0);
        @(posedge clk);
        mon_evt <= '0;
        wr(`EFU_A_EVENT, 32'h2);
        wr(`EFU_A_INT_EN, 32'hFFFFFFFF);
        pulse(28'h400);
        check({20'h0, out_en}, 32'hFF7);
        @(posedge clk);
        svc_out <= 4'h3;
        svc_start <= 1'b1;
        @(posedge clk);
        svc_start <= 1'b0;
        @(negedge clk);
        for (i = 0; i < 100 && svc_busy !== 1'b0; i++) @(negedge clk);
        if (svc_busy !== 1'b0) n_fail++;
        check({4'h0, evt_snap}, 32'h400);
        check({4'h0, msk_snap}, 32'h0FFFFFFF);
        rdc(`EFU_A_EVENT, 32'h0);
        rdc(`EFU_A_OUT_CTRL, 32'h8);
        rdc(`EFU_A_FREQ_SEL, 32'h0);
        check({20'h0, out_en}, 32'hFF7);
        wr(`EFU_A_CTRL, 32'h7);
        wr(`EFU_A_EVT_GEN, 32'h00100000);
        rdc(`EFU_A_EVENT, 32'h00100000);
        check({31'h0, fault_seen}, 32'h1);
        check({19'h0, safe_state, out_en}, 32'hFF7);
        pulse(28'h0200000);
        check({19'h0, safe_state, out_en}, 32'h1000);
        acc(1'b1, `EFU_A_INT_EN, 32'h0, 1'b1);
        rdc(`EFU_A_INT_EN, 32'h0FFFFFFF);
        rdc(`EFU_A_EVENT, 32'h00380000);
        wr(`EFU_A_EVENT, 32'h0FFFFFFF);
        wr(`EFU_A_LOCK, 32'h0);
        wr(`EFU_A_SIG_EXP, 32'h55);
        rdc(`EFU_A_SIG_EXP, 32'h55);
        rdc(`EFU_A_EVENT, 32'h00400000);
        wr(`EFU_A_CTRL, 32'hF);
        wr(`EFU_A_EVENT, 32'h0FFFFFFF);
        rdc(`EFU_A_EVENT, 32'h00800000);
        wr(`EFU_A_CTRL, 32'hB);
        check({31'h0, int_seen}, 32'h0);
        rdc(`EFU_A_DEV_STS, 32'h3);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        rdc(`EFU_A_LOCK, 32'h1);
        check({19'h0, safe_state, out_en}, 32'hFFF);
        print_verdict();
    end
endmodule : event_interrupt_fault_unit_tb
